// file: src/card_detect_pkg.sv
// package for the card presence detect block: settings, timing, states and carriers
// assumes one 10 MHz system clock shared by every file that imports it
package card_detect_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  // contact bounce settles within this time
  localparam int unsigned DEBOUNCE_US = 10_000;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 17;

  // values after reset
  localparam logic RST_DETECT_ENABLE = 1'b1;
  localparam logic RST_POLARITY = 1'b1;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_ABSENT = 3'b001,
    ST_INIT = 3'b011,
    ST_READ = 3'b010,
    ST_REGISTER = 3'b110,
    ST_READY = 3'b111,
    ST_HALTED = 3'b101
  } card_state_t;

  // host setting command: a one-cycle strobe with its value
  typedef struct packed {
    logic valid;
    logic value;
  } setting_cmd_t;

  // requests toward the card and network handlers
  typedef struct packed {
    logic init_req;
    logic read_req;
    logic register_req;
    logic stop_access;
  } card_req_t;

  // answers from those handlers
  typedef struct packed {
    logic init_done;
    logic read_done;
  } card_ack_t;

endpackage : card_detect_pkg

// file: src/presence_filter.sv
// two-flop synchroniser plus debounce filter for the card presence pin
// assumes the pin is asynchronous to i_sys_clk
`timescale 1ns/1ps
module presence_filter (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  import card_detect_pkg::*;

  logic meta_q;
  logic sync_q;
  logic level_q;
  logic rise_q;
  logic fall_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYC - 1);

  wire differs = (sync_q != level_q);
  wire settled = differs && (cnt_q == CNT_LAST);

  // any return to the held level restarts the wait
  assign cnt_d = differs ? (settled ? '0 : cnt_q + 1'b1) : '0;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      level_q <= 1'b0;
      cnt_q <= '0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rise_q <= settled && sync_q;
      fall_q <= settled && !sync_q;
      if (settled) begin
        level_q <= sync_q;
      end
    end
  end

  assign o_level = level_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;

endmodule : presence_filter

// file: src/card_presence_detect.sv
// card presence detection with hot-plug control for a subscriber identity card slot
// assumes host commands arrive as one-cycle strobes on i_sys_clk and that the
// card and network handlers answer with one-cycle done pulses
//
// How it works
// - detection on and card present: initialise card, read it, then request registration.
// - detection on and card absent: treat as removed and stop card reads.
// - detection is on after reset; setting 1 keeps presence following the input.
// - detection off: ignore the input; no new card initialisation begins and a slot in ST_ABSENT halts in ST_HALTED.
// - active level is high after reset; polarity 0 makes low mean inserted.
`timescale 1ns/1ps
module card_presence_detect (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_card_present_input,
  input wire card_detect_pkg::setting_cmd_t i_hotplug_detect_enable_cmd,
  input wire card_detect_pkg::setting_cmd_t i_presence_polarity_setting,
  input wire card_detect_pkg::card_ack_t i_card_ack,
  output card_detect_pkg::card_req_t o_card_req,
  output logic o_card_inserted,
  output logic o_insert_event,
  output logic o_remove_event,
  output card_detect_pkg::card_state_t o_state
);
  import card_detect_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // settings

  logic detect_en_q;
  logic polarity_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      detect_en_q <= RST_DETECT_ENABLE;
      polarity_q <= RST_POLARITY;
    end else begin
      if (i_hotplug_detect_enable_cmd.valid) begin
        detect_en_q <= i_hotplug_detect_enable_cmd.value;
      end
      if (i_presence_polarity_setting.valid) begin
        polarity_q <= i_presence_polarity_setting.value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  presence_filter u_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_card_present_input),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // polarity applied after the filter so a polarity change acts at once
  wire present = polarity_q ? pin_level : !pin_level;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  card_state_t state_q;
  card_state_t state_d;
  logic boot_done_q;
  logic present_q;

  // filter pulses only mark a settled change; the state machine itself
  // works from the level so a polarity flip is seen as insert or removal
  wire pin_change = pin_rise || pin_fall;
  wire hotplug = detect_en_q;
  wire removed = hotplug && !present;
  wire inserted = hotplug && present;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_BOOT: begin
        // with detection off the one start-up read ignores the pin
        if (!hotplug || present) begin
          state_d = ST_INIT;
        end else begin
          state_d = ST_ABSENT;
        end
      end
      ST_ABSENT: begin
        if (inserted) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (removed) begin
          state_d = ST_ABSENT;
        end else if (i_card_ack.init_done) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (removed) begin
          state_d = ST_ABSENT;
        end else if (i_card_ack.read_done) begin
          state_d = ST_REGISTER;
        end
      end
      ST_REGISTER: begin
        state_d = removed ? ST_ABSENT : ST_READY;
      end
      ST_READY: begin
        if (removed) begin
          state_d = ST_ABSENT;
        end
      end
      ST_HALTED: begin
        // detection off after the start-up attempt: nothing further happens
        if (hotplug) begin
          state_d = present ? ST_INIT : ST_ABSENT;
        end
      end
      default: begin
        state_d = ST_ABSENT;
      end
    endcase
    // disabling detection while idle and unread freezes the slot
    if (!hotplug && boot_done_q && (state_q == ST_ABSENT)) begin
      state_d = ST_HALTED;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_BOOT;
      boot_done_q <= 1'b0;
      present_q <= 1'b0;
    end else begin
      state_q <= state_d;
      boot_done_q <= 1'b1;
      present_q <= present;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  card_req_t req_q;
  logic inserted_q;
  logic ins_ev_q;
  logic rem_ev_q;

  wire enter_init = (state_d == ST_INIT) && (state_q != ST_INIT);
  wire enter_read = (state_d == ST_READ) && (state_q != ST_READ);
  wire enter_reg = (state_d == ST_REGISTER);
  // events only while detection is on; one per change of the polarity-applied level
  wire ins_ev = hotplug && present && !present_q && boot_done_q;
  wire rem_ev = hotplug && !present && present_q && boot_done_q;
  wire access_off = (state_d == ST_ABSENT) || (state_d == ST_HALTED);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q <= '0;
      inserted_q <= 1'b0;
      ins_ev_q <= 1'b0;
      rem_ev_q <= 1'b0;
    end else begin
      req_q.init_req <= enter_init;
      req_q.read_req <= enter_read && !removed;
      req_q.register_req <= enter_reg;
      req_q.stop_access <= access_off;
      inserted_q <= (state_d != ST_ABSENT) && (state_d != ST_HALTED)
        && (state_d != ST_BOOT);
      ins_ev_q <= ins_ev || (hotplug && pin_change && present && !present_q);
      rem_ev_q <= rem_ev;
    end
  end

  assign o_card_req = req_q;
  assign o_card_inserted = inserted_q;
  assign o_insert_event = ins_ev_q;
  assign o_remove_event = rem_ev_q;
  assign o_state = state_q;

endmodule : card_presence_detect

// file: testbench/card_presence_detect_properties.sv
// checker for the card presence detect block, bound to its top ports
// assumes one system clock and an active-high asynchronous reset
`timescale 1ns/1ps
module card_presence_detect_checker import card_detect_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_card_present_input,
  input wire setting_cmd_t i_hotplug_detect_enable_cmd,
  input wire setting_cmd_t i_presence_polarity_setting,
  input wire card_ack_t i_card_ack,
  input wire card_req_t o_card_req,
  input wire logic o_card_inserted,
  input wire logic o_insert_event,
  input wire logic o_remove_event,
  input wire card_state_t o_state
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire any_cmd = i_hotplug_detect_enable_cmd.valid | i_presence_polarity_setting.valid;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_read; o_card_req.read_req && o_state == ST_READ; endsequence
  sequence s_reg; o_card_req.register_req ##1 o_state == ST_READY; endsequence
  property p_init_to_read; i_card_ack.init_done && o_state == ST_INIT |=> s_read; endproperty
  a_init_to_read: assert property (p_init_to_read) else $error("no read after init");
  property p_read_to_reg; i_card_ack.read_done && o_state == ST_READ |=> s_reg; endproperty
  a_read_to_reg: assert property (p_read_to_reg) else $error("no registration");
  property p_absent_stops;
    o_state == ST_ABSENT |-> o_card_req.stop_access && !o_card_req.read_req && !o_card_inserted;
  endproperty
  a_absent_stops: assert property (p_absent_stops) else $error("access while absent");
  property p_boot_exit; o_state == ST_BOOT |=> o_state == ST_ABSENT; endproperty
  a_boot_exit: assert property (p_boot_exit) else $error("detection not on at start");
  property p_halted_holds;
    o_state == ST_HALTED && !i_hotplug_detect_enable_cmd.valid
      && !$past(i_hotplug_detect_enable_cmd.valid) |=> o_state == ST_HALTED;
  endproperty
  a_halted_holds: assert property (p_halted_holds) else $error("halted state left");
  // a pin edge must pass synchroniser and filter before any event
  property p_no_fast_event;
    $changed(i_card_present_input) && !any_cmd && !$past(any_cmd) |=>
      !o_insert_event && !o_remove_event;
  endproperty
  a_no_fast_event: assert property (p_no_fast_event) else $error("unfiltered event");
endmodule : card_presence_detect_checker

bind card_presence_detect card_presence_detect_checker i_chk (.*);

// file: testbench/sim_slot_model.sv
// slot with detect switch plus a card handler answering requests
// assumes requests are one-cycle pulses on the system clock
`timescale 1ns/1ps
module sim_slot_model import card_detect_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_card_in,
  input wire card_req_t i_req,
  output logic o_pin,
  output card_ack_t o_ack
);
  logic [2:0] init_dly = 3'h0;
  logic [1:0] read_dly = 2'h0;
  assign o_pin = i_card_in;
  // fixed handler delays, slower than one cycle on purpose
  always @(posedge i_sys_clk) begin
    init_dly <= {init_dly[1:0], i_req.init_req};
    read_dly <= {read_dly[0], i_req.read_req};
  end
  assign o_ack = '{init_done: init_dly[2], read_done: read_dly[1]};
endmodule : sim_slot_model

// file: testbench/card_presence_detect_tb.sv
// self-checking bench for the card presence detect block
// assumes the full debounce time, so the pin is only bounced, never settled
`timescale 1ns/1ps
module card_presence_detect_tb;
  import card_detect_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic card_in = 1'b0;
  setting_cmd_t en_cmd = '0;
  setting_cmd_t pol_cmd = '0;
  logic pin, inserted, ins_ev, rem_ev;
  card_ack_t ack;
  card_req_t req;
  card_state_t state;
  int n_mismatch = 0, compares = 0, n_ins = 0, n_rem = 0, n_init = 0, n_read = 0, n_reg = 0;
  card_presence_detect i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_card_present_input(pin),
    .i_hotplug_detect_enable_cmd(en_cmd), .i_presence_polarity_setting(pol_cmd),
    .i_card_ack(ack), .o_card_req(req), .o_card_inserted(inserted), .o_insert_event(ins_ev),
    .o_remove_event(rem_ev), .o_state(state));
  sim_slot_model i_slot (.i_sys_clk(i_sys_clk), .i_card_in(card_in), .i_req(req),
    .o_pin(pin), .o_ack(ack));
  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    n_ins += int'(ins_ev === 1'b1);
    n_rem += int'(rem_ev === 1'b1);
    n_init += int'(req.init_req === 1'b1);
    n_read += int'(req.read_req === 1'b1);
    n_reg += int'(req.register_req === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task set_cmd(input logic pol, input logic v);
    @(posedge i_sys_clk);
    if (pol) pol_cmd <= '{1'b1, v};
    else en_cmd <= '{1'b1, v};
    @(posedge i_sys_clk);
    pol_cmd <= '0;
    en_cmd <= '0;
  endtask : set_cmd
  // bounded wait, then two more edges so pulses reach the counters
  task wait_st(input card_state_t s);
    for (int k = 0; k < 60 && state !== s; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (state !== s) begin
      n_mismatch++;
      final_report();
    end
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : wait_st
  ////////////////////////////////////////////////////////////////////////////////
  task t_insert;
    wait_st(ST_ABSENT);
    chk({3'h0, req.stop_access}, 4'h1);
    set_cmd(1'b1, 1'b0);
    wait_st(ST_READY);
    chk({3'h0, inserted}, 4'h1);
    chk(4'(n_ins + n_init + n_read + n_reg), 4'h4);
    $display("test insert done");
  endtask : t_insert
  task t_remove;
    set_cmd(1'b1, 1'b1);
    wait_st(ST_ABSENT);
    chk({req.stop_access, 3'(n_rem)}, 4'h9);
    $display("test remove done");
  endtask : t_remove
  task t_bounce;
    @(posedge i_sys_clk);
    card_in <= 1'b1;
    repeat (200) @(posedge i_sys_clk);
    card_in <= 1'b0;
    repeat (50) @(posedge i_sys_clk);
    #1;
    chk({1'b0, state}, {1'b0, ST_ABSENT});
    chk(4'(n_ins), 4'h1);
    $display("test bounce done");
  endtask : t_bounce
  task t_disable;
    set_cmd(1'b0, 1'b0);
    wait_st(ST_HALTED);
    set_cmd(1'b1, 1'b0);
    repeat (20) @(posedge i_sys_clk);
    #1;
    chk({1'b0, state}, {1'b0, ST_HALTED});
    chk(4'(n_ins + n_init), 4'h2);
    set_cmd(1'b0, 1'b1);
    wait_st(ST_READY);
    chk(4'(n_ins + n_init), 4'h3);
    set_cmd(1'b1, 1'b1);
    wait_st(ST_ABSENT);
    $display("test disable done");
  endtask : t_disable
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_insert();
    t_remove();
    t_bounce();
    t_disable();
    final_report();
  end
endmodule : card_presence_detect_tb
